/* File: hdl/bas_access_ctrl.sv */
// Register access security, strap offset and overclock command handling
`timescale 1ns/10ps
`include "bas_params.svh"

module bas_access_ctrl import bas_pkg::*; #(
  parameter int MAX_FAILS = 8  // Wrong attempts before lockup
) (
  input  wire logic        clk,             // Core clock
  input  wire logic        nrst,            // Async reset, active low
  input  wire logic        linkClk,         // Register link clock
  input  wire logic        linkReq,         // Request pulse, link domain
  input  wire logic        linkWrite,       // 1 write, 0 read
  input  wire logic [7:0]  linkAddr,        // Register index
  input  wire logic [15:0] linkWdata,       // Write data
  output logic      [15:0] linkRdata,       // Read data
  output logic             linkDone,        // Answer pulse
  output logic             linkDenied,      // Access refused
  output logic             linkBusy,        // Request in flight
  input  wire logic        enablePin,       // Controller enable pin
  input  wire logic        strapPin,        // Dual pin level
  input  wire logic [3:0]  strapCode,       // Converted strap resistor code
  input  wire logic        marginActive,    // Margining in progress
  output logic      [6:0]  busAddr,         // Effective bus address
  output logic             strapLatched,    // Strap offset captured
  output logic      [8:0]  targetCode,      // Clamped output voltage code
  output logic      [6:0]  loadlinePct,     // Loadline scale in percent
  output logic             ocActive,        // Overclock mode on
  output logic             readUnlocked,    // Reads unlocked
  output logic             writeUnlocked,   // Writes unlocked
  output logic             lockedUp         // Attempt limit reached
);

  // attempt limit is a parameter; the four-bit counter caps it
  if (MAX_FAILS < 1 || MAX_FAILS > 15) begin : g_chk
    $error("MAX_FAILS must be 1..15");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic bas_class_t addrClass(input logic [7:0] a);
    if (a >= `BAS_TELE_FIRST) begin
      return BAS_CLS_TELE;
    end else if (a >= `BAS_CTRL_FIRST) begin
      return BAS_CLS_CTRL;
    end
    return BAS_CLS_CONFIG;
  endfunction

  // Vmax in 5 mV codes: (645 + 120*n)/5 - 1
  function automatic logic [8:0] maxCodeOf(input logic [3:0] v);
    return 9'(`BAS_VMAX_BASE + `BAS_VMAX_STEP * {5'h00, v});
  endfunction

  function automatic logic [8:0] clampCode(input logic signed [10:0] c);
    if (c < 11'sd1) begin
      return 9'h001;
    end else if (c > 11'sd460) begin
      return `BAS_OC_CODE_MAX;
    end
    return c[8:0];
  endfunction

  function automatic logic methodOk(input logic [1:0] m, input logic pin, input logic pwd);
    case (bas_method_t'(m))
      BAS_M_PWD:  return pwd;
      BAS_M_PIN:  return pin;
      BAS_M_BOTH: return pin & pwd;
      default:    return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Link domain: capture request, wait for answer
  // ----------------------------------------
  bas_lstate_t lState_reg;
  logic        reqTgl_reg;
  logic        hWrite_reg;
  logic [7:0]  hAddr_reg;
  logic [15:0] hWdata_reg;
  logic        ackS1_reg, ackS2_reg, ackS3_reg;
  logic        ackTgl_reg;
  logic [15:0] rspData_reg;
  logic        rspDenied_reg;

  // Ack toggle from core, two flops then edge stage
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      ackS1_reg <= 1'b0;
      ackS2_reg <= 1'b0;
      ackS3_reg <= 1'b0;
    end else begin
      ackS1_reg <= ackTgl_reg;
      ackS2_reg <= ackS1_reg;
      ackS3_reg <= ackS2_reg;
    end
  end

  // Request holding; held stable until the answer so the core reads settled words
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      lState_reg <= BAS_L_IDLE;
      reqTgl_reg <= 1'b0;
      hWrite_reg <= 1'b0;
      hAddr_reg  <= 8'h00;
      hWdata_reg <= 16'h0000;
      linkRdata  <= 16'h0000;
      linkDone   <= 1'b0;
      linkDenied <= 1'b0;
      linkBusy   <= 1'b0;
    end else begin
      linkDone <= 1'b0;
      case (lState_reg)
        BAS_L_IDLE: begin
          if (linkReq) begin
            hWrite_reg <= linkWrite;
            hAddr_reg  <= linkAddr;
            hWdata_reg <= linkWdata;
            reqTgl_reg <= ~reqTgl_reg;
            linkBusy   <= 1'b1;
            lState_reg <= BAS_L_WAIT;
          end
        end
        BAS_L_WAIT: begin
          if (ackS2_reg != ackS3_reg) begin
            linkRdata  <= rspData_reg;
            linkDenied <= rspDenied_reg;
            linkDone   <= 1'b1;
            lState_reg <= BAS_L_DONE;
          end
        end
        BAS_L_DONE: begin
          linkBusy   <= 1'b0;
          lState_reg <= BAS_L_IDLE;
        end
        default: lState_reg <= BAS_L_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Core domain: synchronisers
  // ----------------------------------------
  logic reqS1_reg, reqS2_reg, reqS3_reg;
  logic enS1_reg, enSync_reg;
  logic pinS1_reg, pinSync_reg;
  logic reqFire;

  // Two flops each for the request toggle (then edge stage), enable pin and strap pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reqS1_reg   <= 1'b0;
      reqS2_reg   <= 1'b0;
      reqS3_reg   <= 1'b0;
      enS1_reg    <= 1'b0;
      enSync_reg  <= 1'b0;
      pinS1_reg   <= 1'b0;
      pinSync_reg <= 1'b0;
    end else begin
      reqS1_reg   <= reqTgl_reg;
      reqS2_reg   <= reqS1_reg;
      reqS3_reg   <= reqS2_reg;
      enS1_reg    <= enablePin;
      enSync_reg  <= enS1_reg;
      pinS1_reg   <= strapPin;
      pinSync_reg <= pinS1_reg;
    end
  end

  assign reqFire = reqS2_reg ^ reqS3_reg;

  // ----------------------------------------
  // Configuration and password storage
  // ----------------------------------------
  logic [15:0] pwd_reg;
  logic [15:0] try_reg;
  logic [9:0]  secCfg_reg;   // [1:0] rd zone [3:2] wr zone [5:4] rd method [7:6] wr method
  logic [6:0]  baseAddr_reg;
  logic [3:0]  vmax_reg;
  logic [8:0]  baseCode_reg;
  logic [3:0]  strapOff_reg;
  logic [3:0]  failCnt_reg;
  logic        pwdMatch, pinOk, pwdOk, rdAllow, wrAllow, doWrite, doRead;
  bas_class_t  reqCls;

  assign reqCls   = addrClass(hAddr_reg);
  assign pwdMatch = (try_reg == pwd_reg) && (pwd_reg != 16'h0000);
  // unlock by match, refused after lockup
  assign pwdOk    = pwdMatch && !lockedUp;
  // pin counts only after strap capture; disabled protection passes
  assign pinOk    = strapLatched && (pinSync_reg || !secCfg_reg[8]);

  // read and write zone decode; attempt registers stay reachable
  always_comb begin
    case (bas_zone_t'(secCfg_reg[1:0]))
      BAS_ZONE_OPEN:   rdAllow = 1'b1;
      BAS_ZONE_CONFIG: rdAllow = (reqCls != BAS_CLS_CONFIG);
      BAS_ZONE_TELE:   rdAllow = (reqCls == BAS_CLS_TELE);
      default:         rdAllow = 1'b0;
    endcase
    case (bas_zone_t'(secCfg_reg[3:2]))
      BAS_ZONE_OPEN:   wrAllow = 1'b1;
      BAS_ZONE_CONFIG: wrAllow = (reqCls != BAS_CLS_CONFIG);
      default:         wrAllow = 1'b0;
    endcase
    if (hAddr_reg == `BAS_ADDR_TRY_HI || hAddr_reg == `BAS_ADDR_TRY_LO) begin
      rdAllow = 1'b1;
      wrAllow = 1'b1;
    end
    rdAllow = rdAllow || readUnlocked;
    wrAllow = wrAllow || writeUnlocked;
  end

  assign doWrite = reqFire && hWrite_reg && wrAllow;
  assign doRead  = reqFire && !hWrite_reg && rdAllow;

  // Nonvolatile-style settings; password bytes act at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwd_reg      <= `BAS_PWD_RST;
      secCfg_reg   <= `BAS_SEC_RST;
      baseAddr_reg <= `BAS_BASE_RST;
      vmax_reg     <= `BAS_VMAX_RST;
    end else if (doWrite) begin
      case (hAddr_reg)
        `BAS_ADDR_PWD_HI:  pwd_reg[15:8] <= hWdata_reg[7:0];
        `BAS_ADDR_PWD_LO:  pwd_reg[7:0]  <= hWdata_reg[7:0];
        `BAS_ADDR_SEC_CFG: secCfg_reg    <= hWdata_reg[9:0];
        `BAS_ADDR_BASE:    baseAddr_reg  <= hWdata_reg[6:0];
        `BAS_ADDR_VMAX:    vmax_reg      <= hWdata_reg[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      try_reg <= 16'h0000;
    end else if (doWrite && hAddr_reg == `BAS_ADDR_TRY_HI) begin
      try_reg[15:8] <= hWdata_reg[7:0];
    end else if (doWrite && hAddr_reg == `BAS_ADDR_TRY_LO) begin
      try_reg[7:0] <= hWdata_reg[7:0];
    end
  end

  // count failures on low-byte attempts; high byte alone is mid-sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      failCnt_reg <= 4'h0;
      lockedUp    <= 1'b0;
    end else if (doWrite && hAddr_reg == `BAS_ADDR_TRY_LO && !lockedUp) begin
      if ({try_reg[15:8], hWdata_reg[7:0]} != pwd_reg) begin
        failCnt_reg <= failCnt_reg + 4'h1;
        lockedUp    <= (failCnt_reg == 4'(MAX_FAILS - 1));
      end
    end
  end

  // per-direction method; mismatch drops the unlock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readUnlocked  <= 1'b0;
      writeUnlocked <= 1'b0;
    end else begin
      readUnlocked  <= methodOk(secCfg_reg[5:4], pinOk, pwdOk);
      writeUnlocked <= methodOk(secCfg_reg[7:6], pinOk, pwdOk);
    end
  end

  // strap captured once after reset, on first enable; address adds offset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strapLatched <= 1'b0;
      strapOff_reg <= 4'h0;
      busAddr      <= 7'h00;
    end else begin
      if (enSync_reg && !strapLatched) begin
        strapLatched <= 1'b1;
        strapOff_reg <= strapCode;
      end
      busAddr <= secCfg_reg[9] ? 7'(baseAddr_reg + {3'h0, strapOff_reg}) : baseAddr_reg;
    end
  end

  // ----------------------------------------
  // Overclock command path
  // ----------------------------------------
  logic [15:0] ocCmd_reg;
  logic [15:0] pend_reg;
  logic        pendValid_reg;
  logic        ocFollow_reg;
  logic [1:0]  llScale_reg;
  logic [8:0]  ocCode_reg;
  logic        cmdValid, applyPend, baseWr;
  logic [8:0]  baseNew;
  logic signed [10:0] tracked;

  assign cmdValid = doWrite && hAddr_reg == `BAS_ADDR_OC_CMD
                 && hWdata_reg[`BAS_OC_TAG_MSB -: 3] == `BAS_OC_TAG
                 && hWdata_reg[8:0] != 9'h000 && hWdata_reg[8:0] <= `BAS_OC_CODE_MAX;
  assign applyPend = pendValid_reg && !marginActive && enSync_reg;
  assign baseWr    = doWrite && hAddr_reg == `BAS_ADDR_VCODE;
  assign baseNew   = hWdata_reg[8:0];
  // shift by the base code delta
  assign tracked   = 11'(signed'({2'b00, ocCode_reg}) + signed'({2'b00, baseNew})
                   - signed'({2'b00, baseCode_reg}));

  // Command store and pending slot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ocCmd_reg     <= 16'h0000;
      pend_reg      <= 16'h0000;
      pendValid_reg <= 1'b0;
    end else begin
      if (cmdValid) begin
        ocCmd_reg <= hWdata_reg;
        pend_reg  <= hWdata_reg;
      end
      // disable drops a held command; new command wins over apply
      if (!enSync_reg) begin
        pendValid_reg <= 1'b0;
      end else if (cmdValid) begin
        pendValid_reg <= 1'b1;
      end else if (applyPend) begin
        pendValid_reg <= 1'b0;
      end
    end
  end

  // Base code register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baseCode_reg <= `BAS_BOOT_CODE;
    end else if (baseWr) begin
      baseCode_reg <= baseNew;
    end
  end

  // apply command; enable low cancels at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ocActive     <= 1'b0;
      ocFollow_reg <= 1'b0;
      llScale_reg  <= 2'h0;
      ocCode_reg   <= 9'h000;
    end else if (!enSync_reg) begin
      ocActive <= 1'b0;
    end else if (applyPend) begin
      ocActive     <= pend_reg[`BAS_OC_EN_BIT];
      ocFollow_reg <= pend_reg[`BAS_OC_FOLLOW_BIT];
      llScale_reg  <= pend_reg[10:9];
      ocCode_reg   <= pend_reg[8:0];
    end else if (baseWr && ocActive && ocFollow_reg) begin
      ocCode_reg <= clampCode(tracked);
    end
  end

  // override ignores base code; clamp to maximum; scale
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      targetCode  <= `BAS_BOOT_CODE;
      loadlinePct <= 7'd100;
    end else begin
      targetCode <= ((ocActive ? ocCode_reg : baseCode_reg) > maxCodeOf(vmax_reg))
                  ? maxCodeOf(vmax_reg) : (ocActive ? ocCode_reg : baseCode_reg);
      case (ocActive ? llScale_reg : 2'h0)
        2'h0:    loadlinePct <= 7'd100;
        2'h1:    loadlinePct <= 7'd80;
        2'h2:    loadlinePct <= 7'd60;
        default: loadlinePct <= 7'd0;
      endcase
    end
  end

  // ----------------------------------------
  // Answer toward the link
  // ----------------------------------------
  // Read mux, refused reads answer zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rspData_reg   <= 16'h0000;
      rspDenied_reg <= 1'b0;
      ackTgl_reg    <= 1'b0;
    end else if (reqFire) begin
      ackTgl_reg    <= ~ackTgl_reg;
      rspDenied_reg <= hWrite_reg ? !wrAllow : !rdAllow;
      rspData_reg   <= 16'h0000;
      if (doRead) begin
        case (hAddr_reg)
          `BAS_ADDR_PWD_HI:  rspData_reg <= {8'h00, pwd_reg[15:8]};
          `BAS_ADDR_PWD_LO:  rspData_reg <= {8'h00, pwd_reg[7:0]};
          `BAS_ADDR_SEC_CFG: rspData_reg <= {6'h00, secCfg_reg};
          `BAS_ADDR_BASE:    rspData_reg <= {9'h000, baseAddr_reg};
          `BAS_ADDR_VMAX:    rspData_reg <= {12'h000, vmax_reg};
          `BAS_ADDR_TRY_HI:  rspData_reg <= {8'h00, try_reg[15:8]};
          `BAS_ADDR_TRY_LO:  rspData_reg <= {8'h00, try_reg[7:0]};
          `BAS_ADDR_OC_CMD:  rspData_reg <= ocCmd_reg;
          `BAS_ADDR_VCODE:   rspData_reg <= {7'h00, baseCode_reg};
          `BAS_ADDR_STATUS:  rspData_reg <= {pendValid_reg, ocActive, lockedUp, writeUnlocked,
                                             readUnlocked, strapLatched, 2'h0,
                                             failCnt_reg, strapOff_reg};
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_strapOnce;
    @(posedge clk) disable iff (!nrst) strapLatched |=> strapLatched && $stable(strapOff_reg);
  endproperty
  a_strapOnce: assert property (p_strapOnce) else $error("strap offset changed");

  property p_pinLocks;
    @(posedge clk) disable iff (!nrst)
      (secCfg_reg[5:4] == 2'h1 && secCfg_reg[8] && !pinSync_reg) |=> !readUnlocked;
  endproperty
  a_pinLocks: assert property (p_pinLocks) else $error("pin low but reads unlocked");

  property p_forever;
    @(posedge clk) disable iff (!nrst) (secCfg_reg[7:6] == 2'h3) |=> !writeUnlocked;
  endproperty
  a_forever: assert property (p_forever) else $error("forever lock unlocked");

  property p_mismatch;
    @(posedge clk) disable iff (!nrst)
      (doWrite && hAddr_reg == `BAS_ADDR_TRY_LO && secCfg_reg[5:4] == 2'h0
       && {try_reg[15:8], hWdata_reg[7:0]} != pwd_reg) |=> ##1 !readUnlocked;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("wrong attempt left unlocked");

  property p_lockup;
    @(posedge clk) disable iff (!nrst)
      (failCnt_reg == 4'(MAX_FAILS)) |-> lockedUp ##1 (secCfg_reg[5:4] != 2'h0 || !readUnlocked);
  endproperty
  a_lockup: assert property (p_lockup) else $error("lockup not enforced");

  property p_rdSecure;
    @(posedge clk) disable iff (!nrst)
      (reqFire && !hWrite_reg && secCfg_reg[1:0] == 2'h3 && !readUnlocked
       && hAddr_reg != `BAS_ADDR_TRY_HI && hAddr_reg != `BAS_ADDR_TRY_LO)
      |=> rspDenied_reg && rspData_reg == 16'h0000;
  endproperty
  a_rdSecure: assert property (p_rdSecure) else $error("secure read granted");

  property p_wrSecure;
    @(posedge clk) disable iff (!nrst)
      (reqFire && hWrite_reg && secCfg_reg[3:2] != 2'h0 && !writeUnlocked
       && hAddr_reg == `BAS_ADDR_BASE) |=> $stable(baseAddr_reg) && rspDenied_reg;
  endproperty
  a_wrSecure: assert property (p_wrSecure) else $error("locked config write took effect");

  property p_clamp;
    @(posedge clk) disable iff (!nrst)
      $stable(vmax_reg) |-> targetCode <= maxCodeOf(vmax_reg);
  endproperty
  a_clamp: assert property (p_clamp) else $error("target above maximum");

  property p_marginHold;
    @(posedge clk) disable iff (!nrst)
      (marginActive && enSync_reg) |=> $stable(llScale_reg) && $stable(ocFollow_reg);
  endproperty
  a_marginHold: assert property (p_marginHold) else $error("command applied in margining");

  property p_cancel;
    @(posedge clk) disable iff (!nrst)
      !enSync_reg |=> !ocActive ##1 (targetCode <= $past(baseCode_reg));
  endproperty
  a_cancel: assert property (p_cancel) else $error("overclock survived disable");

  property p_badCode;
    @(posedge clk) disable iff (!nrst)
      (doWrite && hAddr_reg == `BAS_ADDR_OC_CMD && !pendValid_reg
       && (hWdata_reg[8:0] == 9'h000 || hWdata_reg[8:0] > `BAS_OC_CODE_MAX))
      |=> !pendValid_reg;
  endproperty
  a_badCode: assert property (p_badCode) else $error("out-of-range code accepted");

endmodule

/* File: hdl/bas_params.svh */
// Constants for the bus access security and overclock block
`ifndef BAS_PARAMS_SVH
`define BAS_PARAMS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define BAS_ADDR_PWD_HI   8'h10
`define BAS_ADDR_PWD_LO   8'h11
`define BAS_ADDR_SEC_CFG  8'h12
`define BAS_ADDR_BASE     8'h13
`define BAS_ADDR_VMAX     8'h14
`define BAS_ADDR_TRY_HI   8'h20
`define BAS_ADDR_TRY_LO   8'h21
`define BAS_ADDR_OC_CMD   8'h30
`define BAS_ADDR_VCODE    8'h31
`define BAS_ADDR_STATUS   8'h60
`define BAS_CTRL_FIRST    8'h20
`define BAS_TELE_FIRST    8'h60

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BAS_OC_TAG        3'h1
`define BAS_OC_TAG_MSB    15
`define BAS_OC_EN_BIT     12
`define BAS_OC_FOLLOW_BIT 11
`define BAS_OC_CODE_MAX   9'h1CC
`define BAS_VMAX_BASE     9'h080
`define BAS_VMAX_STEP     9'h018
`define BAS_PWD_RST       16'h0000
`define BAS_SEC_RST       10'h000
`define BAS_BASE_RST      7'h28
`define BAS_VMAX_RST      4'hF
`define BAS_BOOT_CODE     9'h0C7

`endif

/* File: hdl/bas_pkg.sv */
// Types for the bus access security and overclock block
package bas_pkg;
  typedef enum logic [1:0] {
    BAS_ZONE_OPEN   = 2'h0,
    BAS_ZONE_CONFIG = 2'h1,
    BAS_ZONE_TELE   = 2'h2,
    BAS_ZONE_SECURE = 2'h3
  } bas_zone_t;

  typedef enum logic [1:0] {
    BAS_M_PWD     = 2'h0,
    BAS_M_PIN     = 2'h1,
    BAS_M_BOTH    = 2'h2,
    BAS_M_FOREVER = 2'h3
  } bas_method_t;

  typedef enum logic [1:0] {
    BAS_CLS_CONFIG = 2'h0,
    BAS_CLS_CTRL   = 2'h1,
    BAS_CLS_TELE   = 2'h2
  } bas_class_t;

  typedef enum logic [1:0] {
    BAS_L_IDLE = 2'b00,
    BAS_L_WAIT = 2'b01,
    BAS_L_DONE = 2'b11
  } bas_lstate_t;
endpackage

/* File: test/bas_link_host.sv */
// Link-side host model issuing one register request at a time
`timescale 1ns/10ps
module bas_link_host (
  input  wire logic        linkClk,    // Link clock
  output logic             linkReq,    // Request pulse
  output logic             linkWrite,  // Write select
  output logic      [7:0]  linkAddr,   // Register index
  output logic      [15:0] linkWdata,  // Write data
  input  wire logic [15:0] linkRdata,  // Read data
  input  wire logic        linkDone,   // Answer pulse
  input  wire logic        linkDenied  // Refusal flag
);
  // Idle bus before the first request
  initial begin
    linkReq = 1'b0;
    linkWrite = 1'b0;
    linkAddr = 8'hFF;
    linkWdata = 16'hFFFF;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic den);
    int n;
    n = 0;
    @(negedge linkClk);
    linkReq = 1'b1;
    linkWrite = w;
    linkAddr = a;
    linkWdata = d;
    @(negedge linkClk);
    linkReq = 1'b0;
    // Answer stands a whole cycle, so the falling edge sees it
    do begin
      @(negedge linkClk);
      n++;
    end while (linkDone !== 1'b1 && n < 40);
    rd = linkRdata;
    den = (n < 40) ? linkDenied : ~linkDenied;
    // Released lines show the inverse, not stale values
    linkWrite = ~w;
    linkAddr = ~a;
    linkWdata = ~d;
    @(negedge linkClk);
  endtask
endmodule

/* File: test/bas_access_ctrl_tb.sv */
// Self-checking bench for the access control and overclock block
`timescale 1ns/10ps
`include "bas_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module bas_access_ctrl_tb;
  logic        clk = 1'b0, nrst = 1'b0, linkClk = 1'b0, enablePin = 1'b0;
  logic        strapPin = 1'b0, marginActive = 1'b0, linkReq, linkWrite, linkDone;
  logic        linkDenied, linkBusy, strapLatched, ocActive, readUnlocked;
  logic        writeUnlocked, lockedUp, den;
  logic [3:0]  strapCode = 4'hF;
  logic [6:0]  busAddr, loadlinePct;
  logic [7:0]  linkAddr;
  logic [8:0]  targetCode;
  logic [15:0] linkWdata, linkRdata, rd;
  int          checked = 0, n_fail = 0, cyc = 0;

  always #25 clk = ~clk;
  // Offset start keeps link edges clear of core edges
  initial begin
    #3.1;
    forever #7.5 linkClk = ~linkClk;
  end

  bas_access_ctrl #(.MAX_FAILS(2)) dut (.clk(clk), .nrst(nrst), .linkClk(linkClk),
    .linkReq(linkReq), .linkWrite(linkWrite), .linkAddr(linkAddr), .linkWdata(linkWdata),
    .linkRdata(linkRdata), .linkDone(linkDone), .linkDenied(linkDenied),
    .linkBusy(linkBusy), .enablePin(enablePin), .strapPin(strapPin),
    .strapCode(strapCode), .marginActive(marginActive), .busAddr(busAddr),
    .strapLatched(strapLatched), .targetCode(targetCode), .loadlinePct(loadlinePct),
    .ocActive(ocActive), .readUnlocked(readUnlocked), .writeUnlocked(writeUnlocked),
    .lockedUp(lockedUp));
  bas_link_host host (.linkClk(linkClk), .linkReq(linkReq), .linkWrite(linkWrite),
    .linkAddr(linkAddr), .linkWdata(linkWdata), .linkRdata(linkRdata),
    .linkDone(linkDone), .linkDenied(linkDenied));

  // One transfer, refusal always judged, read data on reads
  task automatic xf(input logic w, input logic [7:0] a, input logic [15:0] d,
                    input logic [15:0] er, input logic ed);
    host.access(w, a, d, rd, den);
    `CHK(den, ed)
    `CHK(linkBusy, 1'b0)
    if (!w) `CHK(rd, er)
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // strap level left alone until latched
  task automatic t_strap;
    clks(5);
    `CHK(strapLatched, 1'b1)
    `CHK(busAddr, 7'h28)
    strapCode = 4'h3;
    $display("test strap done");
  endtask
  // Password set byte-wise, zones closed, then unlocked
  task automatic t_lock;
    xf(1'b1, `BAS_ADDR_PWD_HI, 16'h0012, 16'h0000, 1'b0);
    xf(1'b1, `BAS_ADDR_TRY_HI, 16'h0012, 16'h0000, 1'b0);
    xf(1'b1, `BAS_ADDR_PWD_LO, 16'h0034, 16'h0000, 1'b0);
    clks(2);
    `CHK(writeUnlocked, 1'b0)
    xf(1'b1, `BAS_ADDR_SEC_CFG, 16'h020F, 16'h0000, 1'b0);
    clks(2);
    `CHK(busAddr, 7'h37)
    xf(1'b0, `BAS_ADDR_PWD_HI, 16'h0000, 16'h0000, 1'b1);
    xf(1'b1, `BAS_ADDR_BASE, 16'h0030, 16'h0000, 1'b1);
    xf(1'b1, `BAS_ADDR_TRY_LO, 16'h0034, 16'h0000, 1'b0);
    xf(1'b0, `BAS_ADDR_PWD_HI, 16'h0000, 16'h0012, 1'b0);
    xf(1'b0, `BAS_ADDR_STATUS, 16'h0000, 16'h1C0F, 1'b0);
    // Pin rules reads, writes locked forever behind an open zone
    xf(1'b1, `BAS_ADDR_SEC_CFG, 16'h03D3, 16'h0000, 1'b0);
    clks(2);
    `CHK(writeUnlocked, 1'b0)
    `CHK(readUnlocked, 1'b0)
    xf(1'b0, `BAS_ADDR_PWD_HI, 16'h0000, 16'h0000, 1'b1);
    clks(1);
    strapPin = 1'b1;
    clks(4);
    `CHK(readUnlocked, 1'b1)
    xf(1'b0, `BAS_ADDR_PWD_HI, 16'h0000, 16'h0012, 1'b0);
    xf(1'b1, `BAS_ADDR_SEC_CFG, 16'h020F, 16'h0000, 1'b0);
    $display("test lock done");
  endtask
  // Override, margin hold, bad code, clamp, follow
  task automatic t_oc;
    xf(1'b1, `BAS_ADDR_OC_CMD, 16'h3264, 16'h0000, 1'b0);
    clks(3);
    `CHK(ocActive, 1'b1)
    `CHK(targetCode, 9'd100)
    `CHK(loadlinePct, 7'd80)
    xf(1'b1, `BAS_ADDR_VCODE, 16'h0150, 16'h0000, 1'b0);
    clks(3);
    `CHK(targetCode, 9'd100)
    clks(1);
    marginActive = 1'b1;
    xf(1'b1, `BAS_ADDR_OC_CMD, 16'h36C8, 16'h0000, 1'b0);
    clks(3);
    `CHK(targetCode, 9'd100)
    marginActive = 1'b0;
    clks(3);
    `CHK(targetCode, 9'd200)
    `CHK(loadlinePct, 7'd0)
    xf(1'b1, `BAS_ADDR_OC_CMD, 16'h31CD, 16'h0000, 1'b0);
    clks(3);
    `CHK(targetCode, 9'd200)
    xf(1'b1, `BAS_ADDR_VMAX, 16'h0000, 16'h0000, 1'b0);
    clks(3);
    `CHK(targetCode, 9'h080)
    xf(1'b1, `BAS_ADDR_VMAX, 16'h000F, 16'h0000, 1'b0);
    xf(1'b1, `BAS_ADDR_OC_CMD, 16'h3C64, 16'h0000, 1'b0);
    xf(1'b1, `BAS_ADDR_VCODE, 16'h0160, 16'h0000, 1'b0);
    clks(3);
    `CHK(targetCode, 9'd116)
    `CHK(loadlinePct, 7'd60)
    $display("test overclock done");
  endtask
  // Wrong attempts relock, then lock up for good
  task automatic t_fail;
    xf(1'b1, `BAS_ADDR_TRY_LO, 16'h0035, 16'h0000, 1'b0);
    clks(2);
    `CHK(readUnlocked, 1'b0)
    xf(1'b1, `BAS_ADDR_TRY_LO, 16'h0036, 16'h0000, 1'b0);
    xf(1'b1, `BAS_ADDR_TRY_LO, 16'h0034, 16'h0000, 1'b0);
    clks(2);
    `CHK(lockedUp, 1'b1)
    `CHK(readUnlocked, 1'b0)
    xf(1'b0, `BAS_ADDR_TRY_LO, 16'h0000, 16'h0034, 1'b0);
    clks(1);
    enablePin = 1'b0;
    clks(4);
    `CHK(ocActive, 1'b0)
    `CHK(targetCode, 9'h160)
    $display("test lockup done");
  endtask

  // Cuts a hang short well past the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    clks(8);
    nrst = 1'b1;
    clks(1);
    enablePin = 1'b1;
    t_strap();
    t_lock();
    t_oc();
    t_fail();
    complete_run();
  end
endmodule
